// file: verilog/bss_seq.sv
// transmit beam steering sequencer with APB register access
//
// Behaviour
// - each channel holds its own 6-bit phase code, one step is 5.625 degrees
// - beamforming drives all three channels together and coherently
// - channel 0 phase zero; others 2*pi*d/lambda*sin(angle), d = 2 and 4
// - phase in degrees over 5.625, floored, is the loaded code
// - codes can update every chirp or be held for a whole long-range subframe
// - frame mode: every long-range chirp uses the same precomputed codes
// - default scan spans -60 to +60 degrees in 20 degree steps
// - scan starts at -60, next angle every alternate long-range subframe
// - after +60 the angle wraps back to -60, scanning forever
// - with defaults one sweep takes about 200 ms of frame time
// - start angle and step are configurable, not fixed
// - two subframes per frame; only the long-range one is steered
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
module bss_seq (
   // clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rstn,
   // apb slave
   input  wire logic [7:0]                    paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // frame timing
   input  wire logic                          subframe_start,
   input  wire logic                          subframe_long,
   input  wire logic                          subframe_end,
   input  wire logic                          chirp_start,
   // transmit phase shifters
   output logic      [bss_pkg::CODE_W-1:0]    tx_phase_code0,
   output logic      [bss_pkg::CODE_W-1:0]    tx_phase_code1,
   output logic      [bss_pkg::CODE_W-1:0]    tx_phase_code2,
   output logic                               tx_phase_load,
   output logic      [bss_pkg::NUM_TX-1:0]    tx_enable
);
   import bss_pkg::*;

   // registers
   logic                     ctrl_en_q;
   logic                     ctrl_chirp_q;
   logic signed [ANG_W-1:0]  scan_start_q;
   logic signed [ANG_W-1:0]  scan_step_q;
   logic signed [ANG_W-1:0]  scan_end_q;
   logic        [3:0]        scan_dwell_q;
   logic        [CODE_W-1:0] man_code_q [NUM_TX];
   // bus
   logic                     setup;
   logic                     wr_en;
   logic                     restart;
   logic                     mapped;
   logic        [31:0]       rd_d;
   // sequencing
   bss_sf_t                  sf_q;
   logic                     advance_q;
   logic                     first_chirp_q;
   logic signed [ANG_W-1:0]  angle;
   logic        [CODE_W-1:0] calc_code [NUM_TX];
   logic        [CODE_W-1:0] load_code [NUM_TX];
   logic        [CODE_W-1:0] out_code_q [NUM_TX];
   logic                     sf_long_go;
   logic                     sf_short_go;

   // ---------------- apb slave ----------------
   // one wait-free access phase: pready rises in the first access cycle
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;
   assign restart = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_RESTART_BIT];

   always_comb begin
      mapped = 1'b1;
      rd_d   = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL: begin
            rd_d[CTRL_EN_BIT]    = ctrl_en_q;
            rd_d[CTRL_CHIRP_BIT] = ctrl_chirp_q;
         end
         ADDR_SCAN: begin
            rd_d[SCAN_START_LSB +: ANG_W] = scan_start_q;
            rd_d[SCAN_STEP_LSB +: ANG_W]  = scan_step_q;
            rd_d[SCAN_END_LSB +: ANG_W]   = scan_end_q;
            rd_d[SCAN_DWELL_LSB +: 4]     = scan_dwell_q;
         end
         ADDR_CODE0: rd_d[CODE_W-1:0] = man_code_q[0];
         ADDR_CODE1: rd_d[CODE_W-1:0] = man_code_q[1];
         ADDR_CODE2: rd_d[CODE_W-1:0] = man_code_q[2];
         ADDR_STATUS: begin
            rd_d[ANG_W-1:0]      = angle;
            rd_d[STAT_BEAM_BIT]  = (sf_q == BSS_SF_LONG);
            rd_d[STAT_SHORT_BIT] = (sf_q == BSS_SF_SHORT);
         end
         ADDR_LIVE: begin
            rd_d[CODE_W-1:0]                = out_code_q[0];
            rd_d[LIVE_CH1_LSB +: CODE_W]    = out_code_q[1];
            rd_d[LIVE_CH2_LSB +: CODE_W]    = out_code_q[2];
         end
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup)
            prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_en_q    <= CTRL_EN_RST;
         ctrl_chirp_q <= CTRL_CHIRP_RST;
      end else if (wr_en && paddr == ADDR_CTRL) begin
         ctrl_en_q    <= pwdata[CTRL_EN_BIT];
         ctrl_chirp_q <= pwdata[CTRL_CHIRP_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         scan_start_q <= SCAN_START_RST;
         scan_step_q  <= SCAN_STEP_RST;
         scan_end_q   <= SCAN_END_RST;
         scan_dwell_q <= SCAN_DWELL_RST;
      end else if (wr_en && paddr == ADDR_SCAN) begin
         scan_start_q <= pwdata[SCAN_START_LSB +: ANG_W];
         scan_step_q  <= pwdata[SCAN_STEP_LSB +: ANG_W];
         scan_end_q   <= pwdata[SCAN_END_LSB +: ANG_W];
         scan_dwell_q <= pwdata[SCAN_DWELL_LSB +: 4];
      end
   end

   // per-channel software codes for chirp-by-chirp operation
   genvar ch;
   generate
      for (ch = 0; ch < NUM_TX; ch++) begin : g_man
         localparam logic [7:0] ADDR = ADDR_CODE0 + 8'(4 * ch);
         always_ff @(posedge clk_sys) begin
            if (!rstn)
               man_code_q[ch] <= CODE_RST;
            else if (wr_en && paddr == ADDR)
               man_code_q[ch] <= pwdata[CODE_W-1:0];
         end
      end
   endgenerate

   // ---------------- angle and codes ----------------
   bss_angle_step u_step (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .restart   (restart),
      .advance   (advance_q),
      .cfg_start (scan_start_q),
      .cfg_step  (scan_step_q),
      .cfg_end   (scan_end_q),
      .cfg_dwell (scan_dwell_q),
      .angle_q   (angle)
   );

   bss_phase_calc u_calc (
      .angle (angle),
      .code0 (calc_code[0]),
      .code1 (calc_code[1]),
      .code2 (calc_code[2])
   );

   always_comb begin
      for (int i = 0; i < NUM_TX; i++)
         load_code[i] = ctrl_chirp_q ? man_code_q[i] : calc_code[i];
   end

   // ---------------- subframe sequencing ----------------
   assign sf_long_go  = ctrl_en_q && subframe_start && subframe_long;
   assign sf_short_go = ctrl_en_q && subframe_start && !subframe_long;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sf_q <= BSS_SF_IDLE;
      end else if (!ctrl_en_q || subframe_end) begin
         sf_q <= BSS_SF_IDLE;
      end else if (subframe_start) begin
         sf_q <= subframe_long ? BSS_SF_LONG : BSS_SF_SHORT;
      end
   end

   // the angle moves on after its codes were taken, ready for a later subframe
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         advance_q <= 1'b0;
      else
         advance_q <= sf_long_go && !ctrl_chirp_q;
   end

   // all three codes load in one edge at subframe start, ahead of any chirp
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_TX; i++)
            out_code_q[i] <= CODE_RST;
         tx_phase_load <= 1'b0;
      end else begin
         tx_phase_load <= 1'b0;
         if (sf_long_go) begin
            for (int i = 0; i < NUM_TX; i++)
               out_code_q[i] <= load_code[i];
            tx_phase_load <= 1'b1;
         end else if (sf_short_go) begin
            for (int i = 0; i < NUM_TX; i++)
               out_code_q[i] <= CODE_RST;
            tx_phase_load <= 1'b1;
         end else if (sf_q == BSS_SF_LONG && ctrl_chirp_q && chirp_start) begin
            for (int i = 0; i < NUM_TX; i++)
               out_code_q[i] <= man_code_q[i];
            tx_phase_load <= 1'b1;
         end
         // frame mode: codes stay untouched for every chirp of the subframe
      end
   end

   // long-range: all channels together; short-range: one channel per chirp
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tx_enable     <= '0;
         first_chirp_q <= 1'b0;
      end else if (!ctrl_en_q || subframe_end) begin
         tx_enable     <= '0;
         first_chirp_q <= 1'b0;
      end else if (sf_long_go) begin
         tx_enable     <= '1;
         first_chirp_q <= 1'b0;
      end else if (sf_short_go) begin
         tx_enable     <= NUM_TX'(1);
         first_chirp_q <= 1'b1;
      end else if (sf_q == BSS_SF_SHORT && chirp_start) begin
         first_chirp_q <= 1'b0;
         if (!first_chirp_q)
            tx_enable <= {tx_enable[NUM_TX-2:0], tx_enable[NUM_TX-1]};
      end
   end

   assign tx_phase_code0 = out_code_q[0];
   assign tx_phase_code1 = out_code_q[1];
   assign tx_phase_code2 = out_code_q[2];
endmodule

// file: verilog/bss_pkg.sv
// package: constants and types of the transmit beam steering sequencer
package bss_pkg;
   // channel and code geometry
   localparam int NUM_TX          = 3;
   localparam int CODE_W          = 6;
   localparam int ANG_W           = 6;
   // one code step is 5.625 degrees, held in millidegrees
   localparam int PHASE_STEP_MDEG = 5625;
   // steering angle unit of the scan registers, in degrees
   localparam int ANG_UNIT_DEG    = 5;
   // antenna spacing per channel in wavelengths
   localparam int SPACING_CH0     = 0;
   localparam int SPACING_CH1     = 2;
   localparam int SPACING_CH2     = 4;
   // sine table scale: floor(256*sin) equals floor(spacing*360*sin/5.625) for spacing 4
   localparam int SIN_SPACING     = 4;
   localparam int SIN_W           = 10;
   localparam logic [ANG_W-1:0] ANG_LIMIT = 6'h12;
   localparam logic [ANG_W-1:0] ANG_30    = 6'h06;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SCAN   = 8'h04;
   localparam logic [7:0] ADDR_CODE0  = 8'h08;
   localparam logic [7:0] ADDR_CODE1  = 8'h0C;
   localparam logic [7:0] ADDR_CODE2  = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_LIVE   = 8'h18;

   // field positions
   localparam int CTRL_EN_BIT      = 0;
   localparam int CTRL_CHIRP_BIT   = 1;
   localparam int CTRL_RESTART_BIT = 2;
   localparam int SCAN_START_LSB   = 0;
   localparam int SCAN_STEP_LSB    = 8;
   localparam int SCAN_END_LSB     = 16;
   localparam int SCAN_DWELL_LSB   = 24;
   localparam int STAT_BEAM_BIT    = 8;
   localparam int STAT_SHORT_BIT   = 9;
   localparam int LIVE_CH1_LSB     = 8;
   localparam int LIVE_CH2_LSB     = 16;

   // reset values: scan -60 to +60 degrees in 20 degree steps, two long-range subframes per angle
   localparam logic             CTRL_EN_RST    = 1'b1;
   localparam logic             CTRL_CHIRP_RST = 1'b0;
   localparam logic [ANG_W-1:0] SCAN_START_RST = 6'h34;
   localparam logic [ANG_W-1:0] SCAN_STEP_RST  = 6'h04;
   localparam logic [ANG_W-1:0] SCAN_END_RST   = 6'h0C;
   localparam logic [3:0]       SCAN_DWELL_RST = 4'h2;
   localparam logic [CODE_W-1:0] CODE_RST      = 6'h00;

   typedef enum logic [1:0] {
      BSS_SF_IDLE,
      BSS_SF_LONG,
      BSS_SF_SHORT
   } bss_sf_t;
endpackage

// file: verilog/bss_phase_calc.sv
// steering angle to quantized phase codes for the three transmit channels
`timescale 1ns/100ps
module bss_phase_calc (
   // angle in 5 degree units, signed
   input  wire logic signed [bss_pkg::ANG_W-1:0]  angle,
   // codes per channel
   output logic             [bss_pkg::CODE_W-1:0] code0,
   output logic             [bss_pkg::CODE_W-1:0] code1,
   output logic             [bss_pkg::CODE_W-1:0] code2
);
   import bss_pkg::*;

   logic        [ANG_W-1:0] mag;
   logic        [8:0]       sin_v;
   logic                    exact;
   logic signed [SIN_W-1:0] floor_v;
   logic signed [SIN_W-1:0] scaled [NUM_TX];

   // floor(256*sin) at 5 degree points, 0 to 90 degrees
   function automatic logic [8:0] sin256(input logic [ANG_W-1:0] m);
      case (m)
         6'h00: sin256 = 9'h000;
         6'h01: sin256 = 9'h016;
         6'h02: sin256 = 9'h02C;
         6'h03: sin256 = 9'h042;
         6'h04: sin256 = 9'h057;
         6'h05: sin256 = 9'h06C;
         6'h06: sin256 = 9'h080;
         6'h07: sin256 = 9'h092;
         6'h08: sin256 = 9'h0A4;
         6'h09: sin256 = 9'h0B5;
         6'h0A: sin256 = 9'h0C4;
         6'h0B: sin256 = 9'h0D1;
         6'h0C: sin256 = 9'h0DD;
         6'h0D: sin256 = 9'h0E8;
         6'h0E: sin256 = 9'h0F0;
         6'h0F: sin256 = 9'h0F7;
         6'h10: sin256 = 9'h0FC;
         6'h11: sin256 = 9'h0FF;
         default: sin256 = 9'h100;
      endcase
   endfunction

   always_comb begin
      mag   = angle[ANG_W-1] ? ANG_W'(-angle) : angle;
      sin_v = sin256(mag);
      exact = (mag == '0) || (mag == ANG_30) || (mag >= ANG_LIMIT);
      // negative angles round toward minus infinity as well
      if (angle[ANG_W-1])
         floor_v = -$signed({1'b0, sin_v}) - (exact ? 10'sd0 : 10'sd1);
      else
         floor_v = $signed({1'b0, sin_v});
   end

   // channel 0 is the zero phase reference; others scale with spacing
   genvar ch;
   generate
      for (ch = 0; ch < NUM_TX; ch++) begin : g_ch
         localparam int SP = (ch == 0) ? SPACING_CH0 : (ch == 1) ? SPACING_CH1 : SPACING_CH2;
         if (SP == 0) begin : g_ref
            assign scaled[ch] = '0;
         end else begin : g_sp
            assign scaled[ch] = floor_v >>> $clog2(SIN_SPACING / SP);
         end
      end
   endgenerate

   // low six bits keep the code modulo 64
   assign code0 = scaled[0][CODE_W-1:0];
   assign code1 = scaled[1][CODE_W-1:0];
   assign code2 = scaled[2][CODE_W-1:0];
endmodule

// file: verilog/bss_angle_step.sv
// steering angle stepper: dwell count, step and wrap
`timescale 1ns/100ps
module bss_angle_step (
   // clock and reset
   input  wire logic                             clk_sys,
   input  wire logic                             rstn,
   // control
   input  wire logic                             restart,
   input  wire logic                             advance,
   // scan settings
   input  wire logic signed [bss_pkg::ANG_W-1:0] cfg_start,
   input  wire logic signed [bss_pkg::ANG_W-1:0] cfg_step,
   input  wire logic signed [bss_pkg::ANG_W-1:0] cfg_end,
   input  wire logic        [3:0]                cfg_dwell,
   // current angle
   output logic signed      [bss_pkg::ANG_W-1:0] angle_q
);
   import bss_pkg::*;

   logic        [3:0]       dwell_q;
   logic signed [ANG_W:0]   sum;
   logic                    past_end;
   logic                    out_range;
   logic                    dwell_done;

   always_comb begin
      sum        = (ANG_W+1)'(angle_q) + (ANG_W+1)'(cfg_step);
      past_end   = cfg_step[ANG_W-1] ? (sum < (ANG_W+1)'(cfg_end))
                                     : (sum > (ANG_W+1)'(cfg_end));
      out_range  = (sum > $signed({1'b0, ANG_LIMIT})) || (sum < -$signed({1'b0, ANG_LIMIT}));
      dwell_done = (dwell_q + 4'h1 >= cfg_dwell);
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         angle_q <= SCAN_START_RST;
         dwell_q <= 4'h0;
      end else if (restart) begin
         angle_q <= cfg_start;
         dwell_q <= 4'h0;
      end else if (advance) begin
         if (dwell_done) begin
            dwell_q <= 4'h0;
            // step to next angle, or wrap to the start once the end is passed
            if (past_end || out_range)
               angle_q <= cfg_start;
            else
               angle_q <= sum[ANG_W-1:0];
         end else begin
            dwell_q <= dwell_q + 4'h1;
         end
      end
   end
endmodule

// file: bench/bss_seq_props.sv
// checker: apb answer and phase code load timing of the sequencer
`timescale 1ns/100ps
module bss_seq_props (
   // clock and reset
   input wire logic                        clk_sys,
   input wire logic                        rstn,
   // apb slave
   input wire logic [7:0]                  paddr,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [31:0]                 pwdata,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   // frame timing
   input wire logic                        subframe_start,
   input wire logic                        subframe_long,
   input wire logic                        subframe_end,
   input wire logic                        chirp_start,
   // transmit phase shifters
   input wire logic [bss_pkg::CODE_W-1:0]  tx_phase_code0,
   input wire logic [bss_pkg::CODE_W-1:0]  tx_phase_code1,
   input wire logic [bss_pkg::CODE_W-1:0]  tx_phase_code2,
   input wire logic                        tx_phase_load,
   input wire logic [bss_pkg::NUM_TX-1:0]  tx_enable
);
   import bss_pkg::*;
   logic mapped;
   assign mapped = (paddr <= ADDR_LIVE) && (paddr[1:0] == 2'b00);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_pready_timing: assert property (s_setup |=> s_answer)
      else $error("pready not one cycle after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_unmapped: assert property (pready |-> (pslverr == !mapped))
      else $error("pslverr does not match address map");
   a_prdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
      else $error("prdata changed without setup");
   a_codes_with_load: assert property (!tx_phase_load |-> $stable(tx_phase_code0)
      && $stable(tx_phase_code1) && $stable(tx_phase_code2))
      else $error("codes changed without load pulse");
   a_load_has_cause: assert property (tx_phase_load |-> $past(subframe_start || chirp_start))
      else $error("load pulse without start or chirp");
   a_beam_all_tx: assert property (tx_phase_load && $past(subframe_start && subframe_long)
      |-> tx_enable == 3'b111)
      else $error("long subframe not on all channels");
   a_short_first_tx: assert property (tx_phase_load && $past(subframe_start && !subframe_long)
      |-> tx_enable == 3'b001)
      else $error("short subframe not on channel 0");
   a_short_zero_codes: assert property ($onehot(tx_enable) |-> (tx_phase_code0 == 6'h00)
      && (tx_phase_code1 == 6'h00) && (tx_phase_code2 == 6'h00))
      else $error("short subframe codes not zero");
endmodule

// file: bench/bss_shifter_model.sv
// model of the transmit phase shifters: each channel latches its code on a load pulse
`timescale 1ns/100ps
module bss_shifter_model (
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rstn,
   // codes from the sequencer
   input  wire logic [bss_pkg::CODE_W-1:0]  code0,
   input  wire logic [bss_pkg::CODE_W-1:0]  code1,
   input  wire logic [bss_pkg::CODE_W-1:0]  code2,
   input  wire logic                        load,
   // held settings
   output logic      [bss_pkg::CODE_W-1:0]  set0_q,
   output logic      [bss_pkg::CODE_W-1:0]  set1_q,
   output logic      [bss_pkg::CODE_W-1:0]  set2_q
);
   import bss_pkg::*;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         set0_q <= CODE_RST;
         set1_q <= CODE_RST;
         set2_q <= CODE_RST;
      end else if (load) begin
         set0_q <= code0;
         set1_q <= code1;
         set2_q <= code2;
      end
   end
endmodule

// file: bench/testbench.sv
// self-checking bench of the transmit beam steering sequencer
`timescale 1ns/100ps
`define CHK(got, exp) chk_val(32'(got), 32'(exp))
module testbench;
   import bss_pkg::*;
   typedef struct {int deg; logic [5:0] c1; logic [5:0] c2;} bss_row_t;
   logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic subframe_start, subframe_long, subframe_end, chirp_start, tx_phase_load;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  tx_phase_code0, tx_phase_code1, tx_phase_code2, sh0, sh1, sh2;
   logic [2:0]  tx_enable;
   logic [2:0]  rot [4] = '{3'b001, 3'b001, 3'b010, 3'b100};
   int          degs [4] = '{-10, 15, 40, -10};
   int          failures = 0, total_checks = 0, cycles = 0, i, k, n;
   bss_row_t    rows [8];

   bss_seq u_dut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .subframe_start(subframe_start), .subframe_long(subframe_long),
      .subframe_end(subframe_end), .chirp_start(chirp_start), .tx_phase_code0(tx_phase_code0),
      .tx_phase_code1(tx_phase_code1), .tx_phase_code2(tx_phase_code2),
      .tx_phase_load(tx_phase_load), .tx_enable(tx_enable));
   bss_shifter_model u_model (.clk_sys(clk_sys), .rstn(rstn), .code0(tx_phase_code0),
      .code1(tx_phase_code1), .code2(tx_phase_code2), .load(tx_phase_load),
      .set0_q(sh0), .set1_q(sh1), .set2_q(sh2));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   // ideal phase over one code step, floored, wrapped to six bits
   function automatic logic [5:0] exp_code(input int sp, input int deg);
      int q;
      q = $floor(sp * 360.0 * $sin(deg * 3.14159265358979 / 180.0) / 5.625);
      return 6'(q);
   endfunction
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers counts as a mismatch
      if (pready !== 1'b1)
         failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // m = {subframe_long, subframe_start, subframe_end, chirp_start}; pulses last one cycle
   task automatic pulse(input logic [3:0] m);
      @(posedge clk_sys);
      {subframe_long, subframe_start, subframe_end, chirp_start} <= m;
      @(posedge clk_sys);
      {subframe_start, subframe_end, chirp_start} <= 3'b000;
      #1;
   endtask
   task automatic sf_start(input logic lng);
      pulse({lng, 3'b100});
   endtask
   task automatic long_check(input logic [5:0] e1, input logic [5:0] e2);
      sf_start(1'b1);
      `CHK(tx_phase_load, 1'b1);
      `CHK(tx_enable, 3'b111);
      pulse(4'h1);
      pulse(4'h1);
      `CHK(sh0, 6'h00);
      `CHK(sh1, e1);
      `CHK(sh2, e2);
      pulse(4'h2);
   endtask
   task automatic short_check();
      sf_start(1'b0);
      `CHK(tx_enable, 3'b001);
      for (k = 1; k < 4; k++) begin
         pulse(4'h1);
         `CHK(tx_enable, rot[k]);
      end
      pulse(4'h2);
   endtask

   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {subframe_start, subframe_long, subframe_end, chirp_start} = '0;
      for (i = 0; i < 8; i++) begin
         rows[i].deg = -60 + 20 * (i % 7);
         rows[i].c1 = exp_code(SPACING_CH1, rows[i].deg);
         rows[i].c2 = exp_code(SPACING_CH2, rows[i].deg);
      end
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      `CHK(rd, 32'h00000001);
      apb(1'b0, ADDR_SCAN, 32'h0);
      `CHK(rd, 32'h020C0434);
      apb(1'b1, 8'h1C, 32'hFFFFFFFF);
      `CHK(err, 1'b1);
      apb(1'b0, 8'h1C, 32'h0);
      `CHK(err, 1'b1);
      `CHK(rd, 32'h00000000);
      // every angle twice, with a short subframe after each long one
      for (i = 0; i < 8; i++) begin
         long_check(rows[i].c1, rows[i].c2);
         short_check();
         long_check(rows[i].c1, rows[i].c2);
         short_check();
      end
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[5:0], 6'h38);
      // steering disabled: nothing loads, no channel driven
      apb(1'b1, ADDR_CTRL, 32'h0);
      sf_start(1'b1);
      `CHK({tx_phase_load, tx_enable}, 4'h0);
      pulse(4'h2);
      // chirp mode: manual codes at start and at every chirp
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b1, ADDR_CODE0, 32'h05);
      apb(1'b1, ADDR_CODE1, 32'h2A);
      apb(1'b1, ADDR_CODE2, 32'h3F);
      sf_start(1'b1);
      `CHK(tx_phase_code1, 6'h2A);
      // in a long subframe, angle held at -40 since chirp mode does not step
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd, 32'h00000138);
      apb(1'b1, ADDR_CODE1, 32'h11);
      pulse(4'h1);
      `CHK(tx_phase_code1, 6'h11);
      apb(1'b0, ADDR_LIVE, 32'h0);
      `CHK(rd, 32'h003F1105);
      pulse(4'h2);
      short_check();
      // start -10, step 25, end 60, dwell 1, restart
      apb(1'b1, ADDR_SCAN, 32'h010C053E);
      apb(1'b1, ADDR_CTRL, 32'h5);
      for (i = 0; i < 4; i++) begin
         long_check(exp_code(SPACING_CH1, degs[i]), exp_code(SPACING_CH2, degs[i]));
      end
      // mid-run reset returns outputs and scan start to reset values
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (8) @(posedge clk_sys);
      `CHK({tx_enable, tx_phase_code1, tx_phase_code2}, 15'h0);
      rstn <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[5:0], SCAN_START_RST);
      tally_and_finish();
   end
endmodule

bind bss_seq bss_seq_props u_props (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .subframe_start(subframe_start),
   .subframe_long(subframe_long), .subframe_end(subframe_end), .chirp_start(chirp_start),
   .tx_phase_code0(tx_phase_code0), .tx_phase_code1(tx_phase_code1),
   .tx_phase_code2(tx_phase_code2), .tx_phase_load(tx_phase_load), .tx_enable(tx_enable));
